// ### rtl/clock_reset_boot_strap.sv
// strap decode, bus clock drive, reset sequencing and boot source selection
`include "strap_consts.svh"
module clock_reset_boot_strap #(
  parameter int              RESET_OUT_CYCLES = `RESET_OUT_DELAY,
  parameter logic [23:0]     RESET_VECTOR     = `RESET_VECTOR_DEF
) (
  input  wire logic                    clk_sys_i,
  input  wire logic                    arst_n_i,
  input  wire logic                    clock_double_strap_n_i,
  input  wire logic [1:0]              core_ratio_select_i,
  input  wire logic                    external_boot_strap_i,
  input  wire logic                    link_boot_strap_i,
  input  wire logic                    boot_memory_select_i,
  input  wire logic                    boot_eprom_cs_n_i,
  input  wire logic                    bus_master_i,
  input  wire logic                    host_bus_grant_n_i,
  input  wire logic [2:0]              processor_identifier_i,
  input  wire logic                    bus_clock_i,
  output logic                         bus_clock_out_o,
  output logic                         bus_clock_out_oe_n_o,
  output logic                         bus_clock_keeper_en_o,
  output logic                         boot_memory_select_o,
  output logic                         boot_memory_select_oe_n_o,
  output strap_pkg::clock_cfg_type     clock_cfg_o,
  output strap_pkg::boot_cfg_type      boot_cfg_o,
  output logic                         core_reset_indicator_n_o,
  output logic                         core_start_o,
  output logic [23:0]                  start_address_o
);
  import strap_pkg::*;

  // straps are captured on every clock while reset input is low and for two clocks after it rises; async reset
  // itself may only load constants, so this runs from a separate sync reset
  logic                sync1_r;
  logic                sync2_r;
  logic                in_reset;
  logic                clock_double_r;
  logic [1:0]          ratio_r;
  logic                external_boot_strap_r;
  logic                link_boot_strap_r;
  logic                bms_in_r;
  logic [`CNT_W-1:0]   count_r;
  logic [`CNT_W-1:0]   count_nxt;
  rst_state_type       state_r;
  rst_state_type       state_nxt;

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= 1'b1;
      sync2_r <= sync1_r;
    end
  end
  // only the second flop marks the end of the capture window
  assign in_reset = !sync2_r;

  // sample while held in reset, freeze after release
  always_ff @(posedge clk_sys_i) begin
    if (in_reset) begin
      clock_double_r <= !clock_double_strap_n_i;
      ratio_r        <= core_ratio_select_i;
      external_boot_strap_r        <= external_boot_strap_i;
      link_boot_strap_r        <= link_boot_strap_i;
      bms_in_r       <= boot_memory_select_i;
    end
  end

  // ratio decode; code 11 yields a zero core multiplier so no core rate is implied
  wire       ratio_low   = (ratio_r == `RATIO_CODE_LOW);
  wire       ratio_mid   = (ratio_r == `RATIO_CODE_MID);
  wire       ratio_high  = (ratio_r == `RATIO_CODE_HIGH);
  wire       ratio_bad   = (ratio_r == `RATIO_CODE_BAD);

  wire [3:0] mult_single = ratio_low  ? `CORE_MULT_2 :
                           ratio_mid  ? `CORE_MULT_3 :
                           ratio_high ? `CORE_MULT_4 : 4'h0;
  wire [3:0] mult_double = ratio_low  ? `CORE_MULT_4 :
                           ratio_mid  ? `CORE_MULT_6 :
                           ratio_high ? `CORE_MULT_8 : 4'h0;
  wire [3:0] core_mult   = clock_double_r ? mult_double : mult_single;
  wire [1:0] bus_mult    = clock_double_r ? `BUS_MULT_2 : `BUS_MULT_1;

  // boot decode
  wire sel_resvd = external_boot_strap_r && link_boot_strap_r;
  wire sel_eprom = external_boot_strap_r && !link_boot_strap_r;
  wire sel_host  = !external_boot_strap_r && !link_boot_strap_r && bms_in_r;
  wire sel_spi   = !external_boot_strap_r && link_boot_strap_r && !bms_in_r;
  wire sel_link  = !external_boot_strap_r && link_boot_strap_r && bms_in_r;

  boot_mode_type boot_mode;
  assign boot_mode = sel_resvd ? BOOT_RESVD :
                     sel_eprom ? BOOT_EPROM :
                     sel_host  ? BOOT_HOST  :
                     sel_spi   ? BOOT_SPI   :
                     sel_link  ? BOOT_LINK  : BOOT_NONE;
  // reserved and no-boot leave the channel meaningless, so dma_valid drops
  wire       dma_valid = (boot_mode != BOOT_NONE) && (boot_mode != BOOT_RESVD);
  wire [3:0] dma_chan  = ((boot_mode == BOOT_HOST) || (boot_mode == BOOT_EPROM)) ?
                         `BOOT_DMA_HOST_CHAN : `BOOT_DMA_SERIAL_CHAN;
  wire       bms_drive = sel_eprom && !in_reset;

  // bus clock drive; a granted host owns the pin even while we are master
  wire       host_owns = !host_bus_grant_n_i;
  wire       clk_drive = bus_master_i && !host_owns && !in_reset;
  wire       keeper_on = (processor_identifier_i[2:1] == 2'h0);

  // reset-out sequencer
  always_comb begin
    state_nxt = state_r;
    count_nxt = count_r;
    unique case (state_r)
      // one edge here after release, so the count starts from a clean zero
      RST_HOLD: begin
        count_nxt = '0;
        state_nxt = RST_COUNT;
      end
      RST_COUNT: begin
        count_nxt = count_r + `CNT_W'(1);
        if (count_r == `CNT_W'(RESET_OUT_CYCLES - 2)) begin
          state_nxt = RST_RUN;
        end
      end
      // sticky until the next asynchronous reset
      RST_RUN: begin
        state_nxt = RST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r <= RST_HOLD;
      count_r <= '0;
    end else begin
      state_r <= state_nxt;
      count_r <= count_nxt;
    end
  end

  // next values of the outputs, named so the register blocks stay plain
  clock_cfg_type clock_cfg_nxt;
  boot_cfg_type  boot_cfg_nxt;
  assign clock_cfg_nxt = '{core_mult: core_mult,
                           bus_mult:  bus_mult,
                           doubled:   clock_double_r,
                           ratio_bad: ratio_bad};
  assign boot_cfg_nxt  = '{mode:      boot_mode,
                           dma_valid: dma_valid,
                           dma_chan:  dma_chan};
  wire ready_nxt = (state_nxt == RST_RUN);
  wire start_nxt = (state_r == RST_COUNT) && (state_nxt == RST_RUN);

  // bus clock level is generated upstream; here it is only registered and gated onto the pin
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bus_clock_out_o       <= 1'b0;
      bus_clock_out_oe_n_o  <= 1'b1;
      bus_clock_keeper_en_o <= 1'b0;
    end else begin
      bus_clock_out_o       <= bus_clock_i;
      bus_clock_out_oe_n_o  <= !clk_drive;
      bus_clock_keeper_en_o <= keeper_on;
    end
  end

  // select pin drives only in eprom boot; otherwise it stays an input
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      boot_memory_select_o      <= 1'b1;
      boot_memory_select_oe_n_o <= 1'b1;
    end else begin
      boot_memory_select_o      <= boot_eprom_cs_n_i;
      boot_memory_select_oe_n_o <= !bms_drive;
    end
  end

  // settings freeze with the straps, so they stand until the next reset
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clock_cfg_o <= '0;
      boot_cfg_o  <= '{mode: BOOT_NONE, dma_valid: 1'b0, dma_chan: 4'h0};
    end else begin
      clock_cfg_o <= clock_cfg_nxt;
      boot_cfg_o  <= boot_cfg_nxt;
    end
  end

  // core stays held until the clock generator has had its lock time
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      core_reset_indicator_n_o <= 1'b0;
      core_start_o             <= 1'b0;
      start_address_o          <= 24'h000000;
    end else begin
      core_reset_indicator_n_o <= ready_nxt;
      core_start_o             <= start_nxt;
      start_address_o          <= RESET_VECTOR;
    end
  end
endmodule

// ### rtl/strap_consts.svh
// constant definitions for the clock, reset and boot strap block
`ifndef STRAP_CONSTS_SVH
`define STRAP_CONSTS_SVH
`define RATIO_SEL_W          2
`define RATIO_CODE_LOW       2'h0
`define RATIO_CODE_MID       2'h1
`define RATIO_CODE_HIGH      2'h2
`define RATIO_CODE_BAD       2'h3
`define CORE_MULT_W          4
`define CORE_MULT_2          4'h2
`define CORE_MULT_3          4'h3
`define CORE_MULT_4          4'h4
`define CORE_MULT_6          4'h6
`define CORE_MULT_8          4'h8
`define BUS_MULT_1           2'h1
`define BUS_MULT_2           2'h2
`define BOOT_DMA_HOST_CHAN   4'ha
`define BOOT_DMA_SERIAL_CHAN 4'h8
`define RESET_OUT_DELAY      4080
`define CNT_W                13
`define RESET_VECTOR_DEF     24'h000000
`endif

// ### rtl/strap_pkg.sv
// types for the clock, reset and boot strap block
package strap_pkg;
  typedef enum logic [5:0] {
    BOOT_NONE   = 6'h01,
    BOOT_EPROM  = 6'h02,
    BOOT_HOST   = 6'h04,
    BOOT_SPI    = 6'h08,
    BOOT_LINK   = 6'h10,
    BOOT_RESVD  = 6'h20
  } boot_mode_type;

  typedef struct packed {
    logic [3:0]    core_mult;
    logic [1:0]    bus_mult;
    logic          doubled;
    logic          ratio_bad;
  } clock_cfg_type;

  typedef struct packed {
    boot_mode_type mode;
    logic          dma_valid;
    logic [3:0]    dma_chan;
  } boot_cfg_type;

  typedef enum logic [2:0] {
    RST_HOLD  = 3'h1,
    RST_COUNT = 3'h2,
    RST_RUN   = 3'h4
  } rst_state_type;
endpackage

// ### bench/board_model.sv
// board straps, reset source and bus peers
module board_model (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_req_i,
  input  wire logic [5:0] strap_i,
  input  wire logic [7:0] rnd_i,
  output logic            arst_n_o,
  output logic      [5:0] strap_o,
  output logic      [5:0] peer_o
);
  initial {arst_n_o, strap_o, peer_o} = 13'h0;
  always @(negedge clk_sys_i) begin
    arst_n_o <= !rst_req_i;
    strap_o <= strap_i;
    peer_o <= rnd_i[6:1];
  end
endmodule

// ### bench/clock_reset_boot_strap_properties.sv
// port assertions for the strap block
module clock_reset_boot_strap_properties (
  input wire logic                     clk_sys_i,
  input wire logic                     arst_n_i,
  input wire logic                     boot_eprom_cs_n_i,
  input wire logic                     bus_master_i,
  input wire logic                     host_bus_grant_n_i,
  input wire logic [2:0]               processor_identifier_i,
  input wire logic                     bus_clock_i,
  input wire logic                     bus_clock_out_o,
  input wire logic                     bus_clock_out_oe_n_o,
  input wire logic                     bus_clock_keeper_en_o,
  input wire logic                     boot_memory_select_o,
  input wire logic                     boot_memory_select_oe_n_o,
  input wire strap_pkg::clock_cfg_type clock_cfg_o,
  input wire strap_pkg::boot_cfg_type  boot_cfg_o,
  input wire logic                     core_reset_indicator_n_o,
  input wire logic                     core_start_o
);
  import strap_pkg::*;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  // two cycles up, so $past never sees the release edge
  sequence s_up2; core_reset_indicator_n_o ##1 core_reset_indicator_n_o; endsequence
  sequence s_pulse; core_start_o ##1 !core_start_o; endsequence
  property p_start; $rose(core_reset_indicator_n_o) |-> s_pulse; endproperty
  a_start: assert property (p_start) else $error("start pulse wrong");
  property p_stand; core_reset_indicator_n_o |=> core_reset_indicator_n_o; endproperty
  a_stand: assert property (p_stand) else $error("indicator dropped");
  property p_hold; s_up2 |-> $stable(clock_cfg_o) && $stable(boot_cfg_o); endproperty
  a_hold: assert property (p_hold) else $error("config moved");
  property p_clk_oe;
    s_up2 |-> bus_clock_out_oe_n_o == $past(!bus_master_i || !host_bus_grant_n_i);
  endproperty
  a_clk_oe: assert property (p_clk_oe) else $error("clock enable wrong");
  property p_keep;
    s_up2 |-> bus_clock_keeper_en_o == ($past(processor_identifier_i[2:1]) == 2'h0);
  endproperty
  a_keep: assert property (p_keep) else $error("keeper wrong");
  property p_copy; s_up2 |-> bus_clock_out_oe_n_o || bus_clock_out_o == $past(bus_clock_i);
  endproperty
  a_copy: assert property (p_copy) else $error("bus clock wrong");
  property p_bms_out;
    s_up2 |-> boot_memory_select_oe_n_o || boot_memory_select_o == $past(boot_eprom_cs_n_i);
  endproperty
  a_bms_out: assert property (p_bms_out) else $error("select pin value wrong");
  property p_bms;
    core_reset_indicator_n_o |-> boot_memory_select_oe_n_o == (boot_cfg_o.mode != BOOT_EPROM);
  endproperty
  a_bms: assert property (p_bms) else $error("select drive wrong");
  property p_dma; core_reset_indicator_n_o && boot_cfg_o.mode inside {BOOT_HOST, BOOT_EPROM}
    |-> boot_cfg_o.dma_valid && boot_cfg_o.dma_chan == 4'ha; endproperty
  a_dma: assert property (p_dma) else $error("dma channel wrong");
endmodule
bind clock_reset_boot_strap clock_reset_boot_strap_properties
  clock_reset_boot_strap_properties_i (
    .clk_sys_i                 (clk_sys_i),
    .arst_n_i                  (arst_n_i),
    .boot_eprom_cs_n_i         (boot_eprom_cs_n_i),
    .bus_master_i              (bus_master_i),
    .host_bus_grant_n_i        (host_bus_grant_n_i),
    .processor_identifier_i    (processor_identifier_i),
    .bus_clock_i               (bus_clock_i),
    .bus_clock_out_o           (bus_clock_out_o),
    .bus_clock_out_oe_n_o      (bus_clock_out_oe_n_o),
    .bus_clock_keeper_en_o     (bus_clock_keeper_en_o),
    .boot_memory_select_o      (boot_memory_select_o),
    .boot_memory_select_oe_n_o (boot_memory_select_oe_n_o),
    .clock_cfg_o               (clock_cfg_o),
    .boot_cfg_o                (boot_cfg_o),
    .core_reset_indicator_n_o  (core_reset_indicator_n_o),
    .core_start_o              (core_start_o)
  );

// ### bench/clock_reset_boot_strap_test.sv
// self-checking bench for the strap block
module clock_reset_boot_strap_test;
  timeunit 1ns;
  timeprecision 1ns;
  import strap_pkg::*;
  localparam int N = 16;
  typedef struct packed {clock_cfg_type c; boot_cfg_type b; logic oe_n;} note_type;
  note_type      q[$];
  note_type      nt;
  logic          clk_sys_i = 1'b0;
  logic          rst_req = 1'b1;
  logic    [5:0] strap = 6'h0;
  logic    [7:0] rnd = 8'h35;
  logic    [5:0] strap_w, peer;
  logic          arst_n, bms_oe_n, bco_oe_n, ind_n, start;
  clock_cfg_type ccfg;
  boot_cfg_type  bcfg;
  logic   [23:0] addr;
  int            n_errors = 0, cmp_count = 0, cyc = 0, since = 0;
  initial forever #25 clk_sys_i = ~clk_sys_i;
  board_model board_model_i (.clk_sys_i, .rst_req_i(rst_req), .strap_i(strap), .rnd_i(rnd),
    .arst_n_o(arst_n), .strap_o(strap_w), .peer_o(peer));
  clock_reset_boot_strap #(.RESET_OUT_CYCLES(N)) clock_reset_boot_strap_i (.clk_sys_i,
    .arst_n_i(arst_n), .clock_double_strap_n_i(strap_w[5]), .core_ratio_select_i(strap_w[4:3]),
    .external_boot_strap_i(strap_w[2]), .link_boot_strap_i(strap_w[1]),
    .boot_memory_select_i(strap_w[0]), .boot_eprom_cs_n_i(rnd[7]), .bus_master_i(peer[5]),
    .host_bus_grant_n_i(peer[4]), .processor_identifier_i(peer[3:1]), .bus_clock_i(peer[0]),
    .bus_clock_out_o(), .bus_clock_out_oe_n_o(bco_oe_n), .bus_clock_keeper_en_o(),
    .boot_memory_select_o(), .boot_memory_select_oe_n_o(bms_oe_n), .clock_cfg_o(ccfg),
    .boot_cfg_o(bcfg), .core_reset_indicator_n_o(ind_n), .core_start_o(start),
    .start_address_o(addr));
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // straps {double_n, ratio, ext, link, select}; abort resets again mid count
  task automatic run(input logic [5:0] s, input logic abort);
    note_type e;
    logic [3:0] b;
    b = s[4:3] == 2'h0 ? 4'h2 : s[4:3] == 2'h1 ? 4'h3 : s[4:3] == 2'h2 ? 4'h4 : 4'h0;
    e.c = {s[5] ? b : b << 1, s[5] ? 2'h1 : 2'h2, !s[5], s[4:3] == 2'h3};
    e.b.mode = s[2:1] == 2'h3 ? BOOT_RESVD : s[2] ? BOOT_EPROM : s[1:0] == 2'h0 ? BOOT_NONE
      : s[1:0] == 2'h1 ? BOOT_HOST : s[1:0] == 2'h2 ? BOOT_SPI : BOOT_LINK;
    e.b.dma_valid = e.b.mode inside {BOOT_EPROM, BOOT_HOST, BOOT_SPI, BOOT_LINK};
    e.b.dma_chan = e.b.mode inside {BOOT_EPROM, BOOT_HOST} ? 4'ha : 4'h8;
    e.oe_n = e.b.mode != BOOT_EPROM;
    rst_req <= 1'b1;
    strap <= s;
    repeat (3) @(negedge clk_sys_i);
    check(32'(ind_n), 32'h0);
    check(32'(bco_oe_n), 32'h1);
    if (!abort)
      q.push_back(e);
    rst_req <= 1'b0;
    repeat (3) @(negedge clk_sys_i);
    strap <= ~s;
    for (int k = 0; k < N + 8 && q.size() != 0; k++)
      @(negedge clk_sys_i);
    @(negedge clk_sys_i);
    check(32'(q.size()), 32'h0);
    $display("run %h done", s);
  endtask
  always @(negedge clk_sys_i) begin
    rnd <= lfsr(rnd);
    cyc <= cyc + 1;
    since <= arst_n ? since + 1 : 0;
    if (cyc == 3000) begin
      n_errors++;
      end_sim();
    end else if (start === 1'b1) begin
      check(32'(q.size()), 32'h1);
      nt = '0;
      if (q.size() != 0)
        nt = q.pop_front();
      check(32'(since + 1 >= N && since + 1 <= N + 3), 32'h1);
      check(32'(ccfg), 32'(nt.c));
      check(32'(bcfg.mode), 32'(nt.b.mode));
      check(32'(bcfg.dma_valid), 32'(nt.b.dma_valid));
      if (nt.b.dma_valid)
        check(32'(bcfg.dma_chan), 32'(nt.b.dma_chan));
      check(32'(bms_oe_n), 32'(nt.oe_n));
      check(32'(addr), 32'h0);
    end
  end
  initial begin
    for (int i = 0; i < 8; i++)
      run({i[2], i[1:0], i[2:0]}, 1'b0);
    run(6'h2a, 1'b1);
    for (int i = 0; i < 4; i++)
      run(rnd[5:0], 1'b0);
    end_sim();
  end
endmodule
